// >>> cdt_pkg.sv
// Constants and types shared by the debug and trace port
package cdt_pkg;

  // Register bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte addresses
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_CMD = 8'h08;

  // Control register fields and reset value
  localparam int CTRL_IDM_BIT = 0;
  localparam int CTRL_EDM_BIT = 1;
  localparam logic CTRL_IDM_RST = 1'h0;
  localparam logic CTRL_EDM_RST = 1'h0;

  // Command register fields (write only, read shows pending stop)
  localparam int CMD_STOP_BIT = 0;
  localparam int CMD_RESUME_BIT = 1;
  localparam int CMD_WAIT_SET_BIT = 2;
  localparam int CMD_WAIT_CLR_BIT = 3;

  // Status register fields
  localparam int STAT_HALT_BIT = 16;
  localparam int STAT_WAIT_BIT = 17;
  localparam int STAT_HOLD_BIT = 18;

  // Debug event vector layout
  localparam int EVT_W = 11;
  localparam int EVT_INSTR_CMP1 = 0;
  localparam int EVT_DATA_CMP1_RD = 4;
  localparam int EVT_TRAP = 8;
  localparam int EVT_EXCEPTION = 9;
  localparam int EVT_UNCOND = 10;

  // Pipeline and trace field widths
  localparam int WB_ADDR_W = 30;
  localparam int EXEC_W = 2;
  localparam int TSTAT_W = 4;

  // Trace timing: one trace cycle per two processor clocks
  localparam int TRACE_PERIOD = 2;
  localparam logic TRACE_LAST_PHASE = 1'(TRACE_PERIOD - 1);

  // Trace status code sent after a returned trigger
  localparam logic [3:0] TRC_STAT_TRIGGER = 4'hF;

  // Core run state
  typedef enum logic [2:0] {
    CDT_RUN = 3'b001,
    CDT_WAIT = 3'b010,
    CDT_HALT = 3'b100
  } cdt_state_e;

endpackage

// >>> cdt_trace_pair.sv
// Collects per-cycle trace status into one trace cycle of two clocks
`timescale 1ns/1ps
module cdt_trace_pair #(
  parameter int EXEC_W = 2,
  parameter int TSTAT_W = 4,
  parameter int EVT_W = 11
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Per-cycle status
  input wire logic trace_on,
  input wire logic [EXEC_W-1:0] exec_in,
  input wire logic [TSTAT_W-1:0] tstat_in,
  input wire logic [EVT_W-1:0] evt_in,
  // Pair result, valid while pair_end is high
  output logic pair_end,
  output logic [EXEC_W-1:0] first_exec,
  output logic [EXEC_W-1:0] second_exec,
  output logic [TSTAT_W-1:0] tstat,
  output logic [EVT_W-1:0] evt
);

  logic phase_q;
  logic active_q;
  logic [EXEC_W-1:0] first_q;
  logic [TSTAT_W-1:0] tstat_q;
  logic [EVT_W-1:0] evt_q;

  // Phase and first-cycle capture; trace_on only counts at a pair start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= 1'b0;
      active_q <= 1'b0;
      first_q <= '0;
      tstat_q <= '0;
      evt_q <= '0;
    end else if (clk_en) begin
      phase_q <= (phase_q == cdt_pkg::TRACE_LAST_PHASE) ? 1'b0 : 1'b1;
      if (phase_q != cdt_pkg::TRACE_LAST_PHASE) begin
        active_q <= trace_on; // RULE_24
        first_q <= exec_in;
        tstat_q <= tstat_in;
        evt_q <= evt_in;
      end
    end
  end

  // Second cycle merges with the held first cycle
  assign pair_end = (phase_q == cdt_pkg::TRACE_LAST_PHASE) && active_q; // RULE_23
  assign first_exec = first_q;
  assign second_exec = exec_in;
  assign tstat = tstat_q | tstat_in;
  assign evt = evt_q | evt_in;

endmodule

// >>> cdt_debug_trace_port.sv
// Debug halt, writeback status and real-time trace port of the core
// Function
// RULE_01 - Halt request high stops fetch and execute; clocks keep running; low resumes
// RULE_02 - Halt acknowledge is high exactly while in debug halt mode
// RULE_03 - A stop command from the test port is discarded by reset
// RULE_04 - Halt request held through reset leaves reset already halted
// RULE_05 - Halt request is active high; an active-low debugger output is inverted outside
// RULE_06 - Gated-clock systems use halt request to restart clocks for the debugger
// RULE_07 - Unconditional-event input raises an event and sets its status flag
// RULE_08 - Event gives debug interrupt, halt, or trigger, per debug mode setup
// RULE_09 - Bus-hold acknowledge comes from the bus controller, high while others own bus
// RULE_10 - Writeback-full high exactly when writeback holds an instruction; address valid then
// RULE_11 - Writeback-complete means completing, meaningful only while writeback-full is high
// RULE_12 - Wait-enable output mirrors the wait bit; while set, no fetch or execute
// RULE_13 - Wait state ends on external or timer interrupt, debugger clear, or reset
// RULE_14 - Unused hold, halt and event inputs are tied low outside
// RULE_15 - Trace is always broadcast regardless of triggers, at no performance cost
// RULE_16 - Trigger pulses for debug events only with both debug modes disabled
// RULE_17 - An 11-bit type bus names the events behind each trigger
// RULE_18 - Fabric returns the trigger, maybe qualified, to trigger-in in the same trace cycle
// RULE_19 - Trigger-in high makes the core add trace-status information
// RULE_20 - Two 2-bit execution status fields per trace cycle, first and second clock
// RULE_21 - A 4-bit trace status field is presented every trace cycle
// RULE_22 - Trace-disable high stops trace collection and broadcast
// RULE_23 - Trace-cycle strobe once every two clocks carries both clocks' status
// RULE_24 - On trace-disable, status already collected is broadcast before stopping
// RULE_25 - Type bits: 0-3 instruction compares, 4-7 data compares, 8 trap, 9 exception, 10 uncond
// RULE_26 - All debug and trace outputs are registered on the processor clock
// RULE_27 - Trigger-in is sampled on the processor clock with the trace-cycle strobe
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module cdt_debug_trace_port (
  // Clock, reset, enable
  input wire logic CLOCK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  // Register port
  input wire logic [cdt_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [cdt_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [cdt_pkg::DATA_W-1:0] REG_RDATA,
  // Debug inputs from fabric
  input wire logic BUS_HOLD_ACK_IN,
  input wire logic HALT_REQUEST_IN,
  input wire logic UNCOND_EVENT_IN,
  // Core pipeline side
  input wire logic CORE_WB_VALID,
  input wire logic [cdt_pkg::WB_ADDR_W-1:0] CORE_WB_ADDR,
  input wire logic CORE_WB_DONE,
  input wire logic [cdt_pkg::EVT_UNCOND-1:0] CORE_EVENTS,
  input wire logic [cdt_pkg::EXEC_W-1:0] CORE_EXEC_STATUS,
  input wire logic [cdt_pkg::TSTAT_W-1:0] CORE_TRACE_STATUS,
  input wire logic CORE_EXT_IRQ,
  input wire logic CORE_TIMER_IRQ,
  output logic CORE_RUN_EN,
  output logic CORE_DEBUG_IRQ,
  // Debug status outputs
  output logic WRITEBACK_FULL_OUT,
  output logic [cdt_pkg::WB_ADDR_W-1:0] WRITEBACK_ADDR_OUT,
  output logic WRITEBACK_COMPLETE_OUT,
  output logic WAIT_ENABLE_OUT,
  output logic HALT_ACK_OUT,
  // Trace port
  output logic TRIGGER_OUT,
  output logic [cdt_pkg::EVT_W-1:0] TRIGGER_TYPE_OUT,
  output logic TRACE_CYCLE_STROBE,
  output logic [cdt_pkg::EXEC_W-1:0] FIRST_CYCLE_EXEC_STATUS,
  output logic [cdt_pkg::EXEC_W-1:0] SECOND_CYCLE_EXEC_STATUS,
  output logic [cdt_pkg::TSTAT_W-1:0] TRACE_STATUS_OUT,
  input wire logic TRIGGER_IN,
  input wire logic TRACE_DISABLE_IN
);

  // Address match, shared by read and write decode
  function automatic logic reg_hit(input logic [cdt_pkg::ADDR_W-1:0] addr,
                                   input logic [cdt_pkg::ADDR_W-1:0] off);
    reg_hit = (addr == off);
  endfunction

  logic idm_q;
  logic edm_q;
  logic stop_q;
  logic wait_q;
  logic hold_q;
  logic uncond_prev_q;
  logic irq_q;
  logic run_q;
  logic halt_ack_q;
  logic [cdt_pkg::EVT_W-1:0] status_q;
  logic [cdt_pkg::DATA_W-1:0] rdata_q;
  cdt_pkg::cdt_state_e state_q;
  cdt_pkg::cdt_state_e state_d;
  logic wr_ctrl;
  logic wr_status;
  logic wr_cmd;
  logic uncond_edge;
  logic halt_cond;
  logic trig_allowed;
  logic [cdt_pkg::EVT_W-1:0] evt_now;

  // Write decode and event vector
  assign wr_ctrl = REG_WR && reg_hit(REG_ADDR, cdt_pkg::OFF_CTRL);
  assign wr_status = REG_WR && reg_hit(REG_ADDR, cdt_pkg::OFF_STATUS);
  assign wr_cmd = REG_WR && reg_hit(REG_ADDR, cdt_pkg::OFF_CMD);
  assign uncond_edge = UNCOND_EVENT_IN && !uncond_prev_q; // RULE_07
  assign evt_now = {uncond_edge, CORE_EVENTS}; // RULE_25
  assign halt_cond = HALT_REQUEST_IN || stop_q; // RULE_01
  assign trig_allowed = !idm_q && !edm_q; // RULE_16

  // Debug mode control and input edge register
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      idm_q <= cdt_pkg::CTRL_IDM_RST;
      edm_q <= cdt_pkg::CTRL_EDM_RST;
      uncond_prev_q <= 1'b0;
      hold_q <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_ctrl) begin
        idm_q <= REG_WDATA[cdt_pkg::CTRL_IDM_BIT];
        edm_q <= REG_WDATA[cdt_pkg::CTRL_EDM_BIT];
      end
      uncond_prev_q <= UNCOND_EVENT_IN;
      hold_q <= BUS_HOLD_ACK_IN;
    end
  end

  // Sticky event flags, write one to clear, a new event wins
  genvar gi;
  generate
    for (gi = 0; gi < cdt_pkg::EVT_W; gi++) begin : g_flag
      always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
          status_q[gi] <= 1'b0;
        end else if (CLK_EN) begin
          if (evt_now[gi]) begin
            status_q[gi] <= 1'b1; // RULE_07
          end else if (wr_status && REG_WDATA[gi]) begin
            status_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Stop command; reset drops it, external mode events raise it
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      stop_q <= 1'b0; // RULE_03
    end else if (CLK_EN) begin
      if ((wr_cmd && REG_WDATA[cdt_pkg::CMD_STOP_BIT]) || (edm_q && |evt_now)) begin
        stop_q <= 1'b1; // RULE_08
      end else if (wr_cmd && REG_WDATA[cdt_pkg::CMD_RESUME_BIT]) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Wait bit; interrupts and debugger clear leave wait, a set write wins
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      wait_q <= 1'b0; // RULE_13
    end else if (CLK_EN) begin
      if (wr_cmd && REG_WDATA[cdt_pkg::CMD_WAIT_SET_BIT]) begin
        wait_q <= 1'b1;
      end else if (CORE_EXT_IRQ || CORE_TIMER_IRQ
                   || (wr_cmd && REG_WDATA[cdt_pkg::CMD_WAIT_CLR_BIT])) begin
        wait_q <= 1'b0; // RULE_13
      end
    end
  end

  // Run state selection; halt has priority over wait
  always_comb begin
    state_d = state_q;
    case (state_q)
      cdt_pkg::CDT_RUN: begin
        if (halt_cond) begin
          state_d = cdt_pkg::CDT_HALT; // RULE_01
        end else if (wait_q) begin
          state_d = cdt_pkg::CDT_WAIT; // RULE_12
        end
      end
      cdt_pkg::CDT_WAIT: begin
        if (halt_cond) begin
          state_d = cdt_pkg::CDT_HALT;
        end else if (!wait_q) begin
          state_d = cdt_pkg::CDT_RUN;
        end
      end
      cdt_pkg::CDT_HALT: begin
        if (!halt_cond) begin
          state_d = wait_q ? cdt_pkg::CDT_WAIT : cdt_pkg::CDT_RUN; // RULE_01
        end
      end
      default: begin
        state_d = cdt_pkg::CDT_HALT;
      end
    endcase
  end

  // State and its registered views; reset leaves the core halted
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= cdt_pkg::CDT_HALT; // RULE_04
      run_q <= 1'b0;
      halt_ack_q <= 1'b1;
    end else if (CLK_EN) begin
      state_q <= state_d;
      run_q <= (state_d == cdt_pkg::CDT_RUN);
      halt_ack_q <= (state_d == cdt_pkg::CDT_HALT); // RULE_02
    end
  end

  // Debug interrupt while internal mode owns a pending event
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      irq_q <= 1'b0;
    end else if (CLK_EN) begin
      irq_q <= idm_q && !edm_q && (|status_q || |evt_now); // RULE_08
    end
  end

  // Writeback status registered from the pipeline
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      WRITEBACK_FULL_OUT <= 1'b0;
      WRITEBACK_ADDR_OUT <= '0;
      WRITEBACK_COMPLETE_OUT <= 1'b0;
    end else if (CLK_EN) begin
      WRITEBACK_FULL_OUT <= CORE_WB_VALID; // RULE_10
      WRITEBACK_ADDR_OUT <= CORE_WB_VALID ? CORE_WB_ADDR : '0; // RULE_10
      WRITEBACK_COMPLETE_OUT <= CORE_WB_VALID && CORE_WB_DONE; // RULE_11
    end
  end

  // Register read, data in the following cycle only
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_q <= '0;
    end else if (CLK_EN) begin
      rdata_q <= '0;
      if (REG_RD && reg_hit(REG_ADDR, cdt_pkg::OFF_CTRL)) begin
        rdata_q <= {30'h0, edm_q, idm_q};
      end else if (REG_RD && reg_hit(REG_ADDR, cdt_pkg::OFF_STATUS)) begin
        rdata_q <= {13'h0, hold_q, wait_q, halt_ack_q, 5'h0, status_q};
      end else if (REG_RD && reg_hit(REG_ADDR, cdt_pkg::OFF_CMD)) begin
        rdata_q <= {31'h0, stop_q};
      end
    end
  end

  // Trace pairing of two processor clocks
  logic pair_end;
  logic trig_mark_q;
  logic [cdt_pkg::EXEC_W-1:0] pair_first;
  logic [cdt_pkg::EXEC_W-1:0] pair_second;
  logic [cdt_pkg::TSTAT_W-1:0] pair_tstat;
  logic [cdt_pkg::EVT_W-1:0] pair_evt;

  cdt_trace_pair #(
    .EXEC_W(cdt_pkg::EXEC_W),
    .TSTAT_W(cdt_pkg::TSTAT_W),
    .EVT_W(cdt_pkg::EVT_W)
  ) u_pair (
    .clk(CLOCK),
    .rst_b(RST_B),
    .clk_en(CLK_EN),
    .trace_on(!TRACE_DISABLE_IN), // RULE_22
    .exec_in(CORE_EXEC_STATUS),
    .tstat_in(CORE_TRACE_STATUS),
    .evt_in(evt_now),
    .pair_end(pair_end),
    .first_exec(pair_first),
    .second_exec(pair_second),
    .tstat(pair_tstat),
    .evt(pair_evt)
  );

  // Returned trigger, sampled in the strobe cycle, marks the next trace status
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      trig_mark_q <= 1'b0;
    end else if (CLK_EN) begin
      if (TRACE_CYCLE_STROBE && TRIGGER_IN) begin
        trig_mark_q <= 1'b1; // RULE_27
      end else if (pair_end) begin
        trig_mark_q <= 1'b0;
      end
    end
  end

  // Trace broadcast, independent of triggers
  always_ff @(posedge CLOCK or negedge RST_B) begin
    if (!RST_B) begin
      TRACE_CYCLE_STROBE <= 1'b0;
      FIRST_CYCLE_EXEC_STATUS <= '0;
      SECOND_CYCLE_EXEC_STATUS <= '0;
      TRACE_STATUS_OUT <= '0;
      TRIGGER_OUT <= 1'b0;
      TRIGGER_TYPE_OUT <= '0;
    end else if (CLK_EN) begin
      TRACE_CYCLE_STROBE <= pair_end; // RULE_23
      TRIGGER_OUT <= 1'b0;
      TRIGGER_TYPE_OUT <= '0;
      if (pair_end) begin
        FIRST_CYCLE_EXEC_STATUS <= pair_first; // RULE_20
        SECOND_CYCLE_EXEC_STATUS <= pair_second; // RULE_20
        TRACE_STATUS_OUT <= trig_mark_q ? cdt_pkg::TRC_STAT_TRIGGER : pair_tstat; // RULE_19
        TRIGGER_OUT <= trig_allowed && |pair_evt; // RULE_16
        TRIGGER_TYPE_OUT <= trig_allowed ? pair_evt : '0; // RULE_17
      end
    end
  end

  // Outputs straight from flip-flops
  assign REG_RDATA = rdata_q; // RULE_26
  assign CORE_RUN_EN = run_q;
  assign CORE_DEBUG_IRQ = irq_q;
  assign WAIT_ENABLE_OUT = wait_q; // RULE_12
  assign HALT_ACK_OUT = halt_ack_q;

  // Checks on halt, event, writeback and trace behaviour
  sequence s_pair_close;
    CLK_EN && pair_end;
  endsequence

  sequence s_strobe_then_quiet;
    TRACE_CYCLE_STROBE ##1 !TRACE_CYCLE_STROBE;
  endsequence

  AST_HALT_FOLLOWS_REQUEST: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_01
    CLK_EN && HALT_REQUEST_IN |=> HALT_ACK_OUT && !CORE_RUN_EN)
    else $error("halt request did not halt the core");

  AST_ACK_MATCHES_STATE: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_02
    HALT_ACK_OUT == (state_q == cdt_pkg::CDT_HALT))
    else $error("halt acknowledge disagrees with run state");

  AST_UNCOND_SETS_FLAG: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_07
    CLK_EN && UNCOND_EVENT_IN && !uncond_prev_q |=> status_q[cdt_pkg::EVT_UNCOND])
    else $error("unconditional event flag not set");

  AST_EDM_EVENT_HALTS: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_08
    CLK_EN && edm_q && |evt_now ##1 CLK_EN |=> HALT_ACK_OUT)
    else $error("external mode event did not halt");

  AST_WB_FULL_TRACKS: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_10
    CLK_EN |=> WRITEBACK_FULL_OUT == $past(CORE_WB_VALID))
    else $error("writeback full does not follow pipeline");

  AST_WB_COMPLETE_QUAL: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_11
    WRITEBACK_COMPLETE_OUT |-> WRITEBACK_FULL_OUT)
    else $error("complete without full");

  AST_WAIT_NO_RUN: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_12
    CLK_EN && WAIT_ENABLE_OUT |=> !CORE_RUN_EN)
    else $error("core runs while wait bit set");

  AST_WAIT_EXIT_IRQ: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_13
    CLK_EN && (CORE_EXT_IRQ || CORE_TIMER_IRQ) && !wr_cmd |=> !WAIT_ENABLE_OUT)
    else $error("interrupt did not end wait state");

  AST_TRIG_BLOCKED: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_16
    CLK_EN && (idm_q || edm_q) |=> !TRIGGER_OUT && TRIGGER_TYPE_OUT == '0)
    else $error("trigger while a debug mode is on");

  AST_TRIG_HAS_TYPE: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_17
    TRIGGER_OUT |-> TRACE_CYCLE_STROBE && TRIGGER_TYPE_OUT != '0)
    else $error("trigger without type or strobe");

  AST_STROBE_SPACING: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_23
    TRACE_CYCLE_STROBE && CLK_EN |-> s_strobe_then_quiet)
    else $error("trace strobes back to back");

  AST_DRAIN_ON_DISABLE: assert property (@(posedge CLOCK) disable iff (!RST_B) // RULE_24
    s_pair_close |=> TRACE_CYCLE_STROBE)
    else $error("collected pair was not broadcast");

endmodule

// >>> cdt_fabric_glue.sv
// Fabric glue model between the port and the debugger and trace tool
`timescale 1ns/1ps
module cdt_fabric_glue (
  // Debugger and bus controller side
  input wire logic dbg_halt_b,
  input wire logic ext_grant,
  input wire logic [cdt_pkg::EVT_W-1:0] qual_mask,
  // Core side
  input wire logic trig_out,
  input wire logic [cdt_pkg::EVT_W-1:0] trig_type,
  output logic halt_req,
  output logic bus_hold,
  output logic trig_ret
);
  // Active-low debugger halt is inverted before it reaches the core
  // The same request is the wake-up for any gated clocks of the system
  assign halt_req = ~dbg_halt_b;
  // Bus ownership by another master follows the controller grant
  assign bus_hold = ext_grant;
  // Trigger goes back in the same trace cycle, qualified when a mask is set
  assign trig_ret = trig_out & ((qual_mask == 11'h000) || ((trig_type & qual_mask) != 11'h000));
endmodule

// >>> cdt_debug_trace_port_tb.sv
// Self-checking bench for the debug and trace port with a fabric glue model
`timescale 1ns/1ps
module cdt_debug_trace_port_tb;
  // Stimulus, observed outputs and monitor state
  logic CLOCK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 32'h0;
  logic REG_WR = 1'b0, REG_RD = 1'b0, UNCOND_EVENT_IN = 1'b0, TRACE_DISABLE_IN = 1'b0;
  logic CORE_WB_VALID = 1'b0, CORE_WB_DONE = 1'b0, CORE_EXT_IRQ = 1'b0, CORE_TIMER_IRQ = 1'b0;
  logic [29:0] CORE_WB_ADDR = 30'h0;
  logic [9:0] CORE_EVENTS = 10'h000;
  logic [1:0] CORE_EXEC_STATUS = 2'h0;
  logic [3:0] CORE_TRACE_STATUS = 4'h0;
  logic [31:0] REG_RDATA, d;
  logic HALT_REQUEST_IN, BUS_HOLD_ACK_IN, TRIGGER_IN, CORE_RUN_EN, CORE_DEBUG_IRQ;
  logic WRITEBACK_FULL_OUT, WRITEBACK_COMPLETE_OUT, WAIT_ENABLE_OUT, HALT_ACK_OUT;
  logic TRIGGER_OUT, TRACE_CYCLE_STROBE;
  logic [29:0] WRITEBACK_ADDR_OUT;
  logic [10:0] TRIGGER_TYPE_OUT, trig_seen = 11'h000, qual_mask = 11'h000;
  logic [1:0] FIRST_CYCLE_EXEC_STATUS, SECOND_CYCLE_EXEC_STATUS, h1, h2;
  logic [3:0] TRACE_STATUS_OUT, t1, t2, pat = 4'h0;
  logic dbg_halt_b = 1'b0, ext_grant = 1'b0, pt = 1'b0, gap_on = 1'b1;
  int n_fail = 0, tests_run = 0, gap = 0, n_strobe = 0, s0 = 0;

  // Processor clock, 25 ns period
  always #12.5 CLOCK = ~CLOCK;

  cdt_debug_trace_port cdt_debug_trace_port_i (
    .CLOCK(CLOCK), .RST_B(RST_B), .CLK_EN(1'b1), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .BUS_HOLD_ACK_IN(BUS_HOLD_ACK_IN),
    .HALT_REQUEST_IN(HALT_REQUEST_IN), .UNCOND_EVENT_IN(UNCOND_EVENT_IN),
    .CORE_WB_VALID(CORE_WB_VALID), .CORE_WB_ADDR(CORE_WB_ADDR), .CORE_WB_DONE(CORE_WB_DONE),
    .CORE_EVENTS(CORE_EVENTS), .CORE_EXEC_STATUS(CORE_EXEC_STATUS),
    .CORE_TRACE_STATUS(CORE_TRACE_STATUS), .CORE_EXT_IRQ(CORE_EXT_IRQ),
    .CORE_TIMER_IRQ(CORE_TIMER_IRQ), .CORE_RUN_EN(CORE_RUN_EN), .CORE_DEBUG_IRQ(CORE_DEBUG_IRQ),
    .WRITEBACK_FULL_OUT(WRITEBACK_FULL_OUT), .WRITEBACK_ADDR_OUT(WRITEBACK_ADDR_OUT),
    .WRITEBACK_COMPLETE_OUT(WRITEBACK_COMPLETE_OUT), .WAIT_ENABLE_OUT(WAIT_ENABLE_OUT),
    .HALT_ACK_OUT(HALT_ACK_OUT), .TRIGGER_OUT(TRIGGER_OUT), .TRIGGER_TYPE_OUT(TRIGGER_TYPE_OUT),
    .TRACE_CYCLE_STROBE(TRACE_CYCLE_STROBE), .FIRST_CYCLE_EXEC_STATUS(FIRST_CYCLE_EXEC_STATUS),
    .SECOND_CYCLE_EXEC_STATUS(SECOND_CYCLE_EXEC_STATUS), .TRACE_STATUS_OUT(TRACE_STATUS_OUT),
    .TRIGGER_IN(TRIGGER_IN), .TRACE_DISABLE_IN(TRACE_DISABLE_IN)
  );

  cdt_fabric_glue cdt_fabric_glue_i (
    .dbg_halt_b(dbg_halt_b), .ext_grant(ext_grant), .qual_mask(qual_mask),
    .trig_out(TRIGGER_OUT), .trig_type(TRIGGER_TYPE_OUT), .halt_req(HALT_REQUEST_IN),
    .bus_hold(BUS_HOLD_ACK_IN), .trig_ret(TRIGGER_IN)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CLOCK);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    #1 d = REG_RDATA;
  endtask

  // Bounded wait until the monitor has seen a new trace strobe
  task automatic wait_strobe();
    s0 = n_strobe;
    repeat (8) begin
      @(posedge CLOCK);
      if (n_strobe != s0)
        break;
    end
    if (n_strobe == s0) begin
      n_fail++;
      end_sim();
    end
  endtask

  // One debug event pulse, then its flag, trigger and mode action
  task automatic ev(input int i, input logic [10:0] et, input logic irq, input logic hlt);
    @(posedge CLOCK);
    UNCOND_EVENT_IN <= (i == 10);
    CORE_EVENTS <= 10'h001 << i;
    @(posedge CLOCK);
    UNCOND_EVENT_IN <= 1'b0;
    CORE_EVENTS <= 10'h000;
    cyc(4);
    chk(32'(CORE_DEBUG_IRQ), 32'(irq));
    chk(32'(HALT_ACK_OUT), 32'(hlt));
    chk(32'(trig_seen), 32'(et));
    rd(cdt_pkg::OFF_STATUS);
    chk(32'(d[10:0]), 32'(11'h001 << i));
    wr(cdt_pkg::OFF_STATUS, 32'h000007FF);
    trig_seen = 11'h000;
  endtask

  // Per-cycle status pattern, consecutive cycles always differ
  always @(posedge CLOCK) begin
    pat <= pat + 4'h1;
    CORE_EXEC_STATUS <= pat[1:0];
    CORE_TRACE_STATUS <= 4'h1 << pat[1:0];
  end

  // History of the status presented in the last two cycles
  always @(posedge CLOCK) begin
    h2 = h1;
    h1 = CORE_EXEC_STATUS;
    t2 = t1;
    t1 = CORE_TRACE_STATUS;
    gap = RST_B ? gap + 1 : 0;
    if (!RST_B)
      pt = 1'b0;
  end

  // Trace port monitor: pairing, cadence, trigger marks
  always @(negedge CLOCK) begin
    if (RST_B && TRIGGER_OUT === 1'b1) begin
      trig_seen = trig_seen | TRIGGER_TYPE_OUT;
      chk(32'(TRACE_CYCLE_STROBE), 32'h1);
    end
    if (RST_B && TRACE_CYCLE_STROBE === 1'b1) begin
      chk(32'(FIRST_CYCLE_EXEC_STATUS), 32'(h2));
      chk(32'(SECOND_CYCLE_EXEC_STATUS), 32'(h1));
      chk(32'(TRACE_STATUS_OUT), pt ? 32'hF : 32'(t1 | t2));
      if (gap_on)
        chk(32'(gap), 32'h2);
      pt = TRIGGER_IN;
      gap = 0;
      n_strobe++;
    end
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_fail++;
    end_sim();
  end

  initial begin
    // Reset with halt request held
    cyc(2);
    chk(32'(HALT_ACK_OUT), 32'h1);
    chk(32'({CORE_RUN_EN, WAIT_ENABLE_OUT, TRIGGER_OUT, TRACE_CYCLE_STROBE}), 32'h0);
    @(posedge CLOCK);
    RST_B <= 1'b1;
    cyc(5);
    chk(32'({HALT_ACK_OUT, CORE_RUN_EN}), 32'h2);
    @(posedge CLOCK);
    dbg_halt_b <= 1'b1;
    cyc(3);
    chk(32'({HALT_ACK_OUT, CORE_RUN_EN}), 32'h1);
    $display("test reset_halt done");
    // Mid-run halt; trace keeps its cadence while halted
    @(posedge CLOCK);
    dbg_halt_b <= 1'b0;
    cyc(3);
    chk(32'({HALT_ACK_OUT, CORE_RUN_EN}), 32'h2);
    s0 = n_strobe;
    cyc(6);
    chk(32'(n_strobe - s0), 32'h3);
    @(posedge CLOCK);
    dbg_halt_b <= 1'b1;
    cyc(3);
    chk(32'(HALT_ACK_OUT), 32'h0);
    $display("test halt done");
    // Mode control bits and an unmapped place
    rd(cdt_pkg::OFF_CTRL);
    chk(d, 32'h0);
    wr(cdt_pkg::OFF_CTRL, 32'h3);
    rd(cdt_pkg::OFF_CTRL);
    chk(d, 32'h3);
    cyc(1);
    chk(REG_RDATA, 32'h0);
    wr(cdt_pkg::OFF_CTRL, 32'h0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C);
    chk(d, 32'h0);
    $display("test regs done");
    // Stop command is dropped by a second reset
    wr(cdt_pkg::OFF_CMD, 32'h1);
    cyc(2);
    chk(32'(HALT_ACK_OUT), 32'h1);
    rd(cdt_pkg::OFF_CMD);
    chk(32'(d[0]), 32'h1);
    @(posedge CLOCK);
    RST_B <= 1'b0;
    cyc(2);
    @(posedge CLOCK);
    RST_B <= 1'b1;
    cyc(3);
    chk(32'({HALT_ACK_OUT, CORE_RUN_EN}), 32'h1);
    rd(cdt_pkg::OFF_CMD);
    chk(32'(d[0]), 32'h0);
    $display("test stop_reset done");
    // Wait state entered, left by each of three causes
    for (int k = 0; k < 3; k++) begin
      wr(cdt_pkg::OFF_CMD, 32'h4);
      cyc(2);
      chk(32'({WAIT_ENABLE_OUT, CORE_RUN_EN}), 32'h2);
      if (k == 2)
        wr(cdt_pkg::OFF_CMD, 32'h8);
      else begin
        @(posedge CLOCK);
        CORE_EXT_IRQ <= (k == 0);
        CORE_TIMER_IRQ <= (k == 1);
        @(posedge CLOCK);
        CORE_EXT_IRQ <= 1'b0;
        CORE_TIMER_IRQ <= 1'b0;
      end
      cyc(2);
      chk(32'({WAIT_ENABLE_OUT, CORE_RUN_EN}), 32'h1);
    end
    $display("test wait done");
    // Writeback status, then an empty stage with a stray done
    @(posedge CLOCK);
    CORE_WB_VALID <= 1'b1;
    CORE_WB_ADDR <= 30'h2AAAAAA5;
    CORE_WB_DONE <= 1'b1;
    cyc(1);
    chk(32'({WRITEBACK_FULL_OUT, WRITEBACK_COMPLETE_OUT, WRITEBACK_ADDR_OUT}), 32'hEAAAAAA5);
    @(posedge CLOCK);
    CORE_WB_VALID <= 1'b0;
    cyc(1);
    chk(32'({WRITEBACK_FULL_OUT, WRITEBACK_COMPLETE_OUT, WRITEBACK_ADDR_OUT}), 32'h0);
    // Bus hold shows in status
    @(posedge CLOCK);
    CORE_WB_DONE <= 1'b0;
    ext_grant <= 1'b1;
    cyc(2);
    rd(cdt_pkg::OFF_STATUS);
    chk(32'(d[cdt_pkg::STAT_HOLD_BIT]), 32'h1);
    @(posedge CLOCK);
    ext_grant <= 1'b0;
    $display("test writeback_hold done");
    // Every event source, qualified return, both debug modes
    for (int i = 0; i < 11; i++)
      ev(i, 11'h001 << i, 1'b0, 1'b0);
    @(posedge CLOCK);
    qual_mask <= 11'h400;
    ev(0, 11'h001, 1'b0, 1'b0);
    ev(10, 11'h400, 1'b0, 1'b0);
    @(posedge CLOCK);
    qual_mask <= 11'h000;
    wr(cdt_pkg::OFF_CTRL, 32'h1);
    ev(3, 11'h000, 1'b1, 1'b0);
    wr(cdt_pkg::OFF_CTRL, 32'h2);
    ev(10, 11'h000, 1'b0, 1'b1);
    wr(cdt_pkg::OFF_CMD, 32'h2);
    wr(cdt_pkg::OFF_CTRL, 32'h0);
    cyc(2);
    chk(32'(HALT_ACK_OUT), 32'h0);
    $display("test events done");
    // Trace disable: collected pair goes out, then silence
    wait_strobe();
    TRACE_DISABLE_IN <= 1'b1;
    gap_on = 1'b0;
    s0 = n_strobe;
    cyc(12);
    chk(32'(n_strobe - s0), 32'h1);
    @(posedge CLOCK);
    TRACE_DISABLE_IN <= 1'b0;
    wait_strobe();
    gap_on = 1'b1;
    cyc(8);
    $display("test trace_disable done");
    end_sim();
  end
endmodule
